/* rtl/sssm_defs.vh */
// Constants for the synchronous shift serial mode block.
// Assumes inclusion by bare name from the rtl folder; holds definitions only.
`ifndef SSSM_DEFS_VH
`define SSSM_DEFS_VH

// Bit position of the rate select bit inside the serial control register.
`define SSSM_RATE_BIT        5
// Width of one frame in data bits.
`define SSSM_FRAME_BITS      4'h8
// Slow rate, one bit every 12 oscillator periods.
`define SSSM_SLOW_PERIOD     4'hC
`define SSSM_SLOW_SETUP      4'h3
`define SSSM_SLOW_LOW        4'h6
// Fast rate, one bit every 4 oscillator periods.
`define SSSM_FAST_PERIOD     4'h4
`define SSSM_FAST_SETUP      4'h1
`define SSSM_FAST_LOW        4'h2
// Reset values.
`define SSSM_CTRL_RESET      8'h00
`define SSSM_BYTE_RESET      8'h00
`define SSSM_CNT_RESET       4'h0

`endif

/* rtl/sssm_bit_timer.v */
// Bit phase timer: counts oscillator periods within one shift clock period.
// Assumes clk is the oscillator clock and all inputs are on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "sssm_defs.vh"

module sssm_bit_timer (
    input  wire       clk,
    input  wire       resetn,
    input  wire       run,
    input  wire       fast,
    output reg  [3:0] phase_q,
    output wire       sclk_fall,
    output wire       sclk_rise
);

    // ********************************************************
    // Phase counter
    // ********************************************************
    wire [3:0] period_w  = fast ? `SSSM_FAST_PERIOD : `SSSM_SLOW_PERIOD;
    wire [3:0] setup_w   = fast ? `SSSM_FAST_SETUP  : `SSSM_SLOW_SETUP;
    wire [3:0] low_w     = fast ? `SSSM_FAST_LOW    : `SSSM_SLOW_LOW;
    wire [3:0] last_w    = period_w - 4'h1;
    wire [3:0] hold_w    = period_w - setup_w - low_w;
    wire [3:0] fall_at_w = last_w - low_w;

    // Phase runs 0 .. period-1 and the clock rises at the wrap. An idle timer
    // parks at the hold count, so the first bit of a frame gets the same setup
    // time before the first fall as every later bit.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_q <= `SSSM_CNT_RESET;
        end else if (!run) begin
            phase_q <= hold_w;
        end else if (phase_q == last_w) begin
            phase_q <= `SSSM_CNT_RESET;
        end else begin
            phase_q <= phase_q + 4'h1;
        end
    end

    // Event strobes, one cycle each.
    assign sclk_fall = run && (phase_q == fall_at_w);
    assign sclk_rise = run && (phase_q == last_w);

endmodule
`default_nettype wire

/* rtl/sssm_core.v */
// Synchronous shift serial mode: eight-bit half-duplex shift link master.
// Assumes clk is the oscillator clock; the data pin is sampled through two flops.
`timescale 1ns/10ps
`default_nettype none
`include "sssm_defs.vh"

module sssm_core (
    input  wire       clk,
    input  wire       resetn,
    input  wire [7:0] ctrl_wdata,
    input  wire       ctrl_we,
    output wire [7:0] ctrl_rdata,
    input  wire [7:0] buf_wdata,
    input  wire       buf_we,
    output reg  [7:0] rx_byte_q,
    input  wire       rx_enable,
    output reg        rx_done_q,
    input  wire       rx_done_clr,
    output reg        tx_done_q,
    input  wire       tx_done_clr,
    output wire       busy,
    input  wire       data_in,
    output reg        data_out_q,
    output reg        data_oe_q,
    output reg        shift_clk_q
);

    localparam ST_IDLE = 2'b00;
    localparam ST_TX   = 2'b01;
    localparam ST_RX   = 2'b10;

    reg  [7:0] ctrl_q;
    reg  [1:0] state_q;
    reg  [7:0] shift_q;
    reg  [3:0] bits_q;
    reg        din_meta_q;
    reg        din_sync_q;
    wire [3:0] phase_w;
    wire       fall_w;
    wire       rise_w;
    wire       fast_w;
    wire [3:0] hold_w;
    wire       shift_w;
    wire       tx_end_w;

    // ********************************************************
    // Control register
    // ********************************************************
    // Control holds the rate select; it should not change mid-frame.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= `SSSM_CTRL_RESET;
        end else if (ctrl_we) begin
            ctrl_q <= ctrl_wdata;
        end
    end
    assign ctrl_rdata = ctrl_q;
    assign fast_w     = ctrl_q[`SSSM_RATE_BIT];
    assign busy       = (state_q != ST_IDLE);

    // ********************************************************
    // Data pin synchroniser
    // ********************************************************
    // The pin comes from outside; only the second flop is read.
    // The two flops cost two periods of latency; the receiver allows for it
    // by sampling at the rise: at the slow rate long after the partner's bit has settled, at the fast rate in the first cycle its synchronised copy is valid.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            din_meta_q <= 1'b0;
            din_sync_q <= 1'b0;
        end else begin
            din_meta_q <= data_in;
            din_sync_q <= din_meta_q;
        end
    end

    // The timer runs only while a frame is in progress and parks otherwise,
    // so every frame starts from the same phase.
    sssm_bit_timer u_timer (
        .clk       (clk),
        .resetn    (resetn),
        .run       (busy),
        .fast      (fast_w),
        .phase_q   (phase_w),
        .sclk_fall (fall_w),
        .sclk_rise (rise_w)
    );

    // ********************************************************
    // Bit change point
    // ********************************************************
    // A transmitted bit is replaced hold_w periods after each rise rather
    // than on the rise itself. That keeps the old bit valid across the rise
    // for a partner that clocks on it, and the new bit then leads the fall
    // by exactly the setup time. The cost is a short tail after the eighth
    // rise before the line is released.
    assign hold_w   = fast_w ? (`SSSM_FAST_PERIOD - `SSSM_FAST_SETUP - `SSSM_FAST_LOW)
                             : (`SSSM_SLOW_PERIOD - `SSSM_SLOW_SETUP - `SSSM_SLOW_LOW);
    assign shift_w  = (phase_w == hold_w - 4'h1);
    // The frame ends at the change point that follows the eighth rise.
    assign tx_end_w = (state_q == ST_TX) && shift_w && (bits_q == `SSSM_FRAME_BITS);

    // ********************************************************
    // Frame sequencer
    // ********************************************************
    // The shift clock idles high and is driven by this block in both
    // directions, which is what makes the link half duplex.
    // A control write in the middle of a frame changes the bit timing at
    // once; software is expected to set the rate while the link is idle.
    // A buffer write while busy is dropped, not queued.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q     <= ST_IDLE;
            shift_q     <= `SSSM_BYTE_RESET;
            bits_q      <= `SSSM_CNT_RESET;
            rx_byte_q   <= `SSSM_BYTE_RESET;
            data_out_q  <= 1'b1;
            data_oe_q   <= 1'b0;
            shift_clk_q <= 1'b1;
        end else begin
            case (state_q)
                // Idle parks the clock high; a buffer write wins over a
                // pending receive start in the same cycle.
                ST_IDLE: begin
                    shift_clk_q <= 1'b1;
                    bits_q      <= `SSSM_CNT_RESET;
                    if (buf_we) begin
                        // A write always goes to the transmit shifter.
                        state_q    <= ST_TX;
                        shift_q    <= buf_wdata;
                        data_out_q <= buf_wdata[0];
                        data_oe_q  <= 1'b1;
                    end else if (rx_enable && !rx_done_q) begin
                        state_q   <= ST_RX;
                        data_oe_q <= 1'b0;
                    end
                end
                ST_TX: begin
                    if (fall_w) begin
                        shift_clk_q <= 1'b0;
                    end
                    if (rise_w) begin
                        // The partner may clock the standing bit on this
                        // edge, so the data line is left alone here.
                        shift_clk_q <= 1'b1;
                        bits_q      <= bits_q + 4'h1;
                    end
                    if (tx_end_w) begin
                        // Release the line only once the last bit has had
                        // its hold time after the eighth rise.
                        state_q    <= ST_IDLE;
                        data_oe_q  <= 1'b0;
                        data_out_q <= 1'b1;
                    end else if (shift_w) begin
                        shift_q    <= {1'b1, shift_q[7:1]};
                        data_out_q <= shift_q[1];
                    end
                end
                ST_RX: begin
                    if (fall_w) begin
                        shift_clk_q <= 1'b0;
                    end
                    if (rise_w) begin
                        // Sample on the rise, after the partner had the
                        // whole low time to settle its bit.
                        shift_clk_q <= 1'b1;
                        bits_q      <= bits_q + 4'h1;
                        shift_q     <= {din_sync_q, shift_q[7:1]};
                        if (bits_q == `SSSM_FRAME_BITS - 4'h1) begin
                            state_q   <= ST_IDLE;
                            rx_byte_q <= {din_sync_q, shift_q[7:1]};
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ********************************************************
    // Completion flags
    // ********************************************************
    // Set wins over clear so a completion in the clear cycle is kept.
    // The receive flag also holds off the next reception, so a byte that
    // has not been collected is never overwritten.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_done_q <= 1'b0;
            tx_done_q <= 1'b0;
        end else begin
            if (state_q == ST_RX && rise_w && bits_q == `SSSM_FRAME_BITS - 4'h1) begin
                rx_done_q <= 1'b1;
            end else if (rx_done_clr) begin
                rx_done_q <= 1'b0;
            end
            if (tx_end_w) begin
                tx_done_q <= 1'b1;
            end else if (tx_done_clr) begin
                tx_done_q <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

/* testbench/sssm_core_assertions.sv */
// Port-level timing checker for the shift serial core.
// Assumes it is bound to sssm_core and every signal is on clk.
`timescale 1ns/10ps
`default_nettype none
module sssm_core_chk (
    input wire       clk,
    input wire       resetn,
    input wire [7:0] ctrl_rdata,
    input wire [7:0] buf_wdata,
    input wire       buf_we,
    input wire       rx_enable,
    input wire       rx_done_q,
    input wire       busy,
    input wire       data_out_q,
    input wire       data_oe_q,
    input wire       shift_clk_q
);
    // ****************
    // Shift timing
    // ****************
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Rate is read back from control, so the checks follow the core's rate and a lost control write goes unseen here.
    wire fast = ctrl_rdata[5];
    wire fall = shift_clk_q == 1'b0 && busy;
    chk_low_fast: assert property ($fell(shift_clk_q) && fast |-> ##1 !shift_clk_q ##1 shift_clk_q)
        else $error("fast low time");
    chk_low_slow: assert property ($fell(shift_clk_q) && !fast |-> ##1 !shift_clk_q [*5] ##1 shift_clk_q)
        else $error("slow low time");
    chk_period_fast: assert property ($fell(shift_clk_q) && fast |->
        ##4 ($fell(shift_clk_q) || !$past(busy)))
        else $error("fast period");
    chk_period_slow: assert property ($fell(shift_clk_q) && !fast |->
        ##12 ($fell(shift_clk_q) || !$past(busy)))
        else $error("slow period");
    chk_lead_fast: assert property ($changed(data_out_q) && data_oe_q && fast |-> ##1 $fell(shift_clk_q))
        else $error("fast lead");
    chk_lead_slow: assert property ($changed(data_out_q) && data_oe_q && !fast |-> ##3 $fell(shift_clk_q))
        else $error("slow lead");
    chk_rise_hold: assert property ($rose(shift_clk_q) && data_oe_q |-> $stable(data_out_q))
        else $error("rise hold");
    chk_setup_fast: assert property ($fell(shift_clk_q) && fast |-> $stable(data_out_q))
        else $error("fast setup");
    chk_setup_slow: assert property ($fell(shift_clk_q) && !fast |-> data_out_q == $past(data_out_q, 2))
        else $error("slow setup");
    chk_idle_pins: assert property (!busy |-> shift_clk_q && !data_oe_q)
        else $error("idle pins");
    chk_tx_start: assert property (buf_we && !busy |=>
        busy && data_oe_q && data_out_q == $past(buf_wdata[0]))
        else $error("tx start");
    chk_rx_start: assert property (rx_enable && !rx_done_q && !busy && !buf_we |=> busy && !data_oe_q)
        else $error("rx start");
    cov_fast: cover property ($fell(shift_clk_q) && fast);
    cov_slow: cover property ($fell(shift_clk_q) && !fast);
    cov_rx: cover property ($rose(rx_done_q));
    cov_rx_low: cover property (fall && !data_oe_q);
endmodule
bind sssm_core sssm_core_chk u_chk (.clk(clk), .resetn(resetn), .ctrl_rdata(ctrl_rdata), .buf_wdata(buf_wdata),
    .buf_we(buf_we), .rx_enable(rx_enable), .rx_done_q(rx_done_q), .busy(busy), .data_out_q(data_out_q),
    .data_oe_q(data_oe_q), .shift_clk_q(shift_clk_q));
`default_nettype wire

/* testbench/sssm_partner.sv */
// Far-side shift register: takes bits while the clock is low, moves its own bit after the rise.
// Assumes the bench resolves the shared data pin from both drivers.
`timescale 1ns/10ps
`default_nettype none
module sssm_partner (
    input  wire       clk,
    input  wire       shift_clk,
    input  wire       pin,
    input  wire       drive_en,
    input  wire [7:0] drive_byte,
    output wire       p_out,
    output reg  [7:0] got_byte_q = 8'h00,
    output reg  [3:0] got_cnt_q = 4'h0
);
    reg [2:0] idx_q  = 3'h0;
    reg       sclk_q = 1'b1;
    // Lowest bit first; a 3-bit index keeps each frame at eight bits.
    assign p_out = drive_byte[idx_q];
    // Edges are found one clock late on the fast clock: the own bit moves a
    // cycle after the rise, the device bit is taken a cycle after the fall.
    always @(posedge clk) begin
        sclk_q <= shift_clk;
        if (!drive_en) begin
            idx_q <= 3'h0;
        end else if (shift_clk && !sclk_q) begin
            idx_q <= idx_q + 3'h1;
        end
        if (!shift_clk && sclk_q) begin
            got_byte_q <= {pin, got_byte_q[7:1]};
            got_cnt_q  <= got_cnt_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

/* testbench/sssm_core_tb.sv */
// Self-checking bench for the shift serial core and its far-side model.
// Assumes core, partner and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module sssm_core_tb;
    logic       clk = 0, resetn = 0, ctrl_we = 0, buf_we = 0, rx_enable = 0, rx_done_clr = 0, tx_done_clr = 0;
    logic [7:0] ctrl_wdata = 8'h00, buf_wdata = 8'h00, p_byte = 8'h00;
    logic       p_en = 0, pin, last_pin = 0;
    wire  [7:0] ctrl_rdata, rx_byte_q, got_byte;
    wire  [3:0] got_cnt;
    wire        rx_done_q, tx_done_q, busy, data_out_q, data_oe_q, shift_clk_q, p_out;
    int         bad_count = 0, checked = 0;
    // ****************
    // Pin and instances
    // ****************
    // A released pin toggles every cycle, so a stale bit never passes as data.
    always @* pin = data_oe_q ? data_out_q : (p_en ? p_out : ~last_pin);
    always @(posedge clk) last_pin <= pin;
    sssm_core DUT (.clk(clk), .resetn(resetn), .ctrl_wdata(ctrl_wdata), .ctrl_we(ctrl_we), .ctrl_rdata(ctrl_rdata),
        .buf_wdata(buf_wdata), .buf_we(buf_we), .rx_byte_q(rx_byte_q), .rx_enable(rx_enable), .rx_done_q(rx_done_q),
        .rx_done_clr(rx_done_clr), .tx_done_q(tx_done_q), .tx_done_clr(tx_done_clr), .busy(busy), .data_in(pin),
        .data_out_q(data_out_q), .data_oe_q(data_oe_q), .shift_clk_q(shift_clk_q));
    sssm_partner u_far (.clk(clk), .shift_clk(shift_clk_q), .pin(pin), .drive_en(p_en), .drive_byte(p_byte),
        .p_out(p_out), .got_byte_q(got_byte), .got_cnt_q(got_cnt));
    initial forever #4 clk = ~clk;
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Bounded wait: sel 0 waits for idle, sel 1 for the receive flag.
    task automatic wait_for(input logic sel);
        int n;
        for (n = 0; n < 400 && (sel ? rx_done_q !== 1'b1 : busy !== 1'b0); n++) begin
            @(posedge clk);
            #1;
        end
        check("wait", 8'h00, {7'h00, n == 400});
        if (n == 400) complete_run;
    endtask
    task automatic set_rate(input logic fast);
        @(posedge clk);
        ctrl_we <= 1'b1;
        ctrl_wdata <= {2'b00, fast, 5'h00};
        @(posedge clk);
        ctrl_we <= 1'b0;
        @(posedge clk);
        #1;
        check("ctrl", {2'b00, fast, 5'h00}, ctrl_rdata);
    endtask
    task automatic clear_flag(input logic rx);
        @(posedge clk);
        rx_done_clr <= rx;
        tx_done_clr <= !rx;
        @(posedge clk);
        rx_done_clr <= 1'b0;
        tx_done_clr <= 1'b0;
        @(posedge clk);
        #1;
        check("flags", 8'h00, {6'h00, rx_done_q, tx_done_q});
    endtask
    // Pin levels after reset.
    task automatic reset_values;
        #1;
        check("pins", 8'h05, {3'h0, busy, data_oe_q, data_out_q, rx_done_q | tx_done_q, shift_clk_q});
        check("rx buffer", 8'h00, rx_byte_q);
    endtask
    // Send one byte; a second write in mid-frame must be ignored.
    task automatic tx_frame(input logic fast, input logic [7:0] b);
        logic [3:0] c0;
        set_rate(fast);
        @(posedge clk);
        c0 = got_cnt;
        buf_we <= 1'b1;
        buf_wdata <= b;
        @(posedge clk);
        buf_we <= 1'b0;
        repeat (3) @(posedge clk);
        buf_we <= 1'b1;
        buf_wdata <= ~b;
        @(posedge clk);
        buf_we <= 1'b0;
        wait_for(1'b0);
        check("tx byte", b, got_byte);
        check("tx bits", {4'h0, c0 + 4'h8}, {4'h0, got_cnt});
        check("tx done", 8'h01, {7'h00, tx_done_q});
        clear_flag(1'b0);
    endtask
    // Receive one byte from the far side.
    task automatic rx_frame(input logic fast, input logic [7:0] b);
        set_rate(fast);
        @(posedge clk);
        p_byte <= b;
        p_en <= 1'b1;
        @(posedge clk);
        rx_enable <= 1'b1;
        wait_for(1'b1);
        check("rx byte", b, rx_byte_q);
        @(posedge clk);
        rx_enable <= 1'b0;
        p_en <= 1'b0;
        clear_flag(1'b1);
    endtask
    // A transmit must leave the receive buffer alone.
    task automatic split_buffer;
        tx_frame(1'b0, 8'h3C);
        check("rx kept", 8'h96, rx_byte_q);
    endtask
    initial begin
        repeat (11) @(posedge clk);
        reset_values();
        @(posedge clk);
        resetn <= 1'b1;
        reset_values();
        tx_frame(1'b1, 8'hA5);
        rx_frame(1'b1, 8'h96);
        split_buffer();
        rx_frame(1'b0, 8'h5A);
        complete_run();
    end
endmodule
`default_nettype wire
